//--- lcrb_bank.sv
// Local configuration bank: serial ROM port, pin config, clock dividers,
// mode status. Assumes host and loader ports are on core_clk_i.
//
// What this block does
// - Loader overrun sets sticky flag, drops valid
// - Bit 4 reads synced serial data input
// - Bit 3 drives serial data output, resets 0
// - Bit 2 drives serial clock pin, resets 0
// - Bit 1 drives chip select high, resets 0
// - Bit 0 reads valid header found
// - Pin-one field selects polarity or driven level
// - Pin-zero field uses same encodings
// - UART divider divides by two to field
// - UART divider resets to undivided
// - Pulse divider resets to code 101
// - Dividers writable by host and loader
// - Mode bit reflects mode pin
// - Loader writes only fixed offsets 0x09 and 0x0A
// - Internal pin follows pin in input modes, optionally inverted
// - Interrupt pulse lasts one divided period
`timescale 1ns/1ns
`include "lcrb_defs.svh"
module lcrb_bank
   import lcrb_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input  wire logic       core_clk_i,     // System clock, 250 MHz
   input  wire logic       resetn_i,       // Sync reset, active low
   input  wire logic       overlay_i,      // Bank overlays offsets 0-3
   input  wire logic       host_rd_i,      // Host read strobe
   input  wire logic       host_wr_i,      // Host write strobe
   input  wire logic [3:0] host_addr_i,    // Host I/O offset
   input  wire logic [7:0] host_wdata_i,   // Host write data
   output logic      [7:0] host_rdata_o,   // Host read data
   input  wire logic       ldr_wr_i,       // Loader write strobe
   input  wire logic [3:0] ldr_addr_i,     // Loader offset
   input  wire logic [7:0] ldr_wdata_i,    // Loader write data
   input  wire logic       ldr_hdr_ok_i,   // Loader found header, pulse
   input  wire logic       ldr_overrun_i,  // Loader ran off end, pulse
   input  wire logic       ldr_busy_i,     // Loader owns ROM pins
   input  wire logic       ldr_cs_i,       // Loader chip select
   input  wire logic       ldr_ck_i,       // Loader serial clock
   input  wire logic       ldr_do_i,       // Loader data to ROM
   output logic            rom_absent_o,   // No usable ROM image
   input  wire logic       serial_rom_data_in_pin_i,  // From ROM
   output logic            serial_rom_data_out_pin_o, // To ROM
   output logic            serial_rom_clock_pin_o,    // ROM clock
   output logic            serial_rom_select_pin_o,   // ROM select
   input  wire logic       mode_pin_i,     // 1 = local bus mode
   input  wire logic [1:0] multipurpose_pins_i,   // Pin levels
   output logic      [1:0] multipurpose_pins_o,   // Driven levels
   output logic      [1:0] multipurpose_pins_oe_o,// High = driving
   output logic      [1:0] pin_state_o,    // Internal pin signals
   output logic            uart_clk_en_o,  // UART clock enable tick
   input  wire logic       irq_pulse_req_i,// Pulse interrupt request
   output logic            irq_pulse_o     // Pulse interrupt out
);

   generate
      if (DIV_W != 3) begin : g_chk
         $error("lcrb_bank: divider fields are three bits");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Address decode

   // Generic overlay moves the host view down to offsets 0-3
   function automatic logic host_hit(input logic [3:0] a,
                                     input logic       ov);
      return (a[3] == !ov) && !a[2];
   endfunction

   function automatic logic ldr_hit(input logic [3:0] a,
                                    input logic [3:0] ofs);
      return a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic       din_m_r, din_s_r;
   logic       mode_m_r, mode_s_r;
   logic [1:0] mio_m_r, mio_s_r;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         din_m_r  <= 1'b0;
         din_s_r  <= 1'b0;
         mode_m_r <= 1'b0;
         mode_s_r <= 1'b0;
         mio_m_r  <= 2'h0;
         mio_s_r  <= 2'h0;
      end else begin
         din_m_r  <= serial_rom_data_in_pin_i;
         din_s_r  <= din_m_r;
         mode_m_r <= mode_pin_i;
         mode_s_r <= mode_m_r;
         mio_m_r  <= multipurpose_pins_i;
         mio_s_r  <= mio_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register storage

   logic [2:0] rom_ctl_r, rom_ctl_nxt;   // {dout, clk, cs}
   logic       vld_r, vld_nxt;
   logic       ovr_r, ovr_nxt;
   logic [3:0] mic_r, mic_nxt;
   logic [5:0] div_r, div_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic [1:0] pst_r, pst_nxt;
   logic       hhit;
   logic [1:0] hidx;
   logic [7:0] rom_view;

   always_comb begin
      hhit        = host_hit(host_addr_i, overlay_i);
      hidx        = host_addr_i[1:0];
      rom_ctl_nxt = rom_ctl_r;
      mic_nxt     = mic_r;
      div_nxt     = div_r;
      // Overrun wins over a late header report
      ovr_nxt     = ovr_r | ldr_overrun_i;
      vld_nxt     = (vld_r | ldr_hdr_ok_i) & ~ovr_nxt;
      if (host_wr_i && hhit) begin
         unique case (hidx)
            `LCRB_IDX_ROM: rom_ctl_nxt =
               host_wdata_i[`LCRB_ROM_DOUT:`LCRB_ROM_CS];
            `LCRB_IDX_MIC: mic_nxt  = host_wdata_i[3:0];
            `LCRB_IDX_DIV: div_nxt  = host_wdata_i[5:0];
            `LCRB_IDX_MODE: ;
         endcase
      end
      // Loader has fixed offsets and wins a same-cycle clash
      if (ldr_wr_i && ldr_hit(ldr_addr_i, `LCRB_OFS_MIC))
         mic_nxt = ldr_wdata_i[3:0];
      if (ldr_wr_i && ldr_hit(ldr_addr_i, `LCRB_OFS_DIV))
         div_nxt = ldr_wdata_i[5:0];
      rom_view = {2'h0, ovr_r, din_s_r, rom_ctl_r, vld_r};
      rd_nxt   = rd_r;
      if (host_rd_i) begin
         rd_nxt = `LCRB_RD_RST;
         if (hhit) begin
            unique case (hidx)
               `LCRB_IDX_ROM:  rd_nxt = rom_view;
               `LCRB_IDX_MIC:  rd_nxt = {4'h0, mic_r};
               `LCRB_IDX_DIV:  rd_nxt = {2'h0, div_r};
               `LCRB_IDX_MODE: rd_nxt = {7'h00, mode_s_r};
            endcase
         end
      end
      // Output modes show the driven level internally
      for (int i = 0; i < 2; i++) begin
         pst_nxt[i] = mic_r[2*i+1] ? mic_r[2*i]
                                   : (mio_s_r[i] ^ mic_r[2*i]);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rom_ctl_r <= `LCRB_ROM_CTL_RST;
         vld_r     <= 1'b0;
         ovr_r     <= 1'b0;
         mic_r     <= `LCRB_MIC_RST;
         div_r     <= {`LCRB_DIV_UART_RST, `LCRB_DIV_IRQ_RST};
         rd_r      <= `LCRB_RD_RST;
         pst_r     <= 2'h0;
      end else begin
         rom_ctl_r <= rom_ctl_nxt;
         vld_r     <= vld_nxt;
         ovr_r     <= ovr_nxt;
         mic_r     <= mic_nxt;
         div_r     <= div_nxt;
         rd_r      <= rd_nxt;
         pst_r     <= pst_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pins

   // Bit-banged port; loader borrows the pins only while it runs
   assign serial_rom_data_out_pin_o = ldr_busy_i ? ldr_do_i
                                                 : rom_ctl_r[2];
   assign serial_rom_clock_pin_o    = ldr_busy_i ? ldr_ck_i
                                                 : rom_ctl_r[1];
   assign serial_rom_select_pin_o   = ldr_busy_i ? ldr_cs_i
                                                 : rom_ctl_r[0];
   assign rom_absent_o              = ~vld_r;
   assign multipurpose_pins_oe_o    = {mic_r[3], mic_r[1]};
   assign multipurpose_pins_o       = {mic_r[2], mic_r[0]};
   assign pin_state_o               = pst_r;
   assign host_rdata_o              = rd_r;

   ////////////////////////////////////////////////////////////////////
   // Dividers and pulse interrupt

   logic           irq_tick;
   lcrb_ip_state_t ip_r, ip_nxt;
   logic           pend_r, pend_nxt;

   lcrb_pow2_div #(.DIV_W(DIV_W)) u_uart_div (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div_r[5:3]),
      .tick_o     (uart_clk_en_o)
   );

   // Reserved codes 110 and 111 still divide, by 64 and 128
   lcrb_pow2_div #(.DIV_W(DIV_W)) u_irq_div (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div_r[2:0]),
      .tick_o     (irq_tick)
   );

   always_comb begin
      ip_nxt   = ip_r;
      pend_nxt = pend_r;
      unique case (ip_r)
         LCRB_IP_IDLE: if (irq_pulse_req_i) ip_nxt = LCRB_IP_WAIT;
         LCRB_IP_WAIT: if (irq_tick) ip_nxt = LCRB_IP_PULSE;
         LCRB_IP_PULSE: begin
            if (irq_pulse_req_i) pend_nxt = 1'b1;
            if (irq_tick) begin
               ip_nxt   = pend_nxt ? LCRB_IP_WAIT : LCRB_IP_IDLE;
               pend_nxt = 1'b0;
            end
         end
         default: ip_nxt = LCRB_IP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ip_r   <= LCRB_IP_IDLE;
         pend_r <= 1'b0;
      end else begin
         ip_r   <= ip_nxt;
         pend_r <= pend_nxt;
      end
   end

   assign irq_pulse_o = (ip_r == LCRB_IP_PULSE);

   ////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] plen_r;
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) plen_r <= 8'h00;
      else plen_r <= irq_pulse_o ? 8'(plen_r + 8'h01) : 8'h00;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   a_overrun_sticky: assert property (
      ldr_overrun_i |=> ovr_r && !vld_r && rom_absent_o [*3])
      else $error("overrun flag not sticky or valid kept");
   a_din_readback: assert property (
      host_rd_i && hhit && hidx == `LCRB_IDX_ROM
      |=> host_rdata_o[`LCRB_ROM_DIN] == $past(din_s_r))
      else $error("data input bit mismatch");
   a_dout_write: assert property (
      host_wr_i && hhit && hidx == `LCRB_IDX_ROM && !ldr_busy_i ##1
      !ldr_busy_i |-> serial_rom_data_out_pin_o ==
      $past(host_wdata_i[`LCRB_ROM_DOUT]))
      else $error("data out pin not following write");
   a_clk_cs_write: assert property (
      host_wr_i && hhit && hidx == `LCRB_IDX_ROM ##1 !ldr_busy_i
      |-> serial_rom_clock_pin_o == $past(host_wdata_i[2]) &&
          serial_rom_select_pin_o == $past(host_wdata_i[1]))
      else $error("clock or select pin not following write");
   a_valid_read: assert property (
      host_rd_i && hhit && hidx == `LCRB_IDX_ROM
      |=> host_rdata_o[`LCRB_ROM_VLD] == !$past(rom_absent_o))
      else $error("valid bit mismatch");
   a_pin_drive: assert property (
      mic_r[3] |-> (multipurpose_pins_oe_o[1] &&
      multipurpose_pins_o[1] == mic_r[2]) ##1
      pin_state_o[1] == $past(mic_r[2]))
      else $error("pin one output mode wrong");
   a_pin_polarity: assert property (
      !mic_r[1] && $stable(mic_r) |=> pin_state_o[0] ==
      ($past(mio_s_r[0]) ^ $past(mic_r[0])))
      else $error("pin zero polarity wrong");
   // Tick register is still clear on the first edge after reset
   a_uart_div_one: assert property (
      $past(resetn_i) && div_r[5:3] == 3'h0 &&
      $past(div_r[5:3]) == 3'h0 |-> uart_clk_en_o)
      else $error("undivided UART clock dropped a tick");
   a_irq_len: assert property (
      $fell(irq_pulse_o) |-> plen_r == (8'h01 << div_r[2:0]))
      else $error("interrupt pulse length wrong");
   a_ldr_div_write: assert property (
      ldr_wr_i && ldr_addr_i == `LCRB_OFS_DIV
      |=> div_r == $past(ldr_wdata_i[5:0]))
      else $error("loader divider write lost");
   a_reserved_zero: assert property (
      host_rd_i && hhit && hidx != `LCRB_IDX_ROM
      |=> host_rdata_o[7:6] == 2'h0)
      else $error("reserved bits read nonzero");
   a_mode_read: assert property (
      host_rd_i && hhit && hidx == `LCRB_IDX_MODE
      |=> host_rdata_o == {7'h00, $past(mode_s_r)})
      else $error("mode status mismatch");

   c_irq_pulse:  cover property ($fell(irq_pulse_o));
   c_overrun:    cover property (ldr_overrun_i ##1 ovr_r);
   c_overlay_rd: cover property (host_rd_i && hhit && overlay_i);
   c_pin_out:    cover property (mic_r == 4'hF);
endmodule // lcrb_bank

//--- lcrb_defs.svh
// Offsets, field positions, reset values of the local config bank.
// Assumes inclusion by bare name from the bank design file.
`ifndef LCRB_DEFS_SVH
`define LCRB_DEFS_SVH
`define LCRB_OFS_ROM      4'h8
`define LCRB_OFS_MIC      4'h9
`define LCRB_OFS_DIV      4'hA
`define LCRB_OFS_MODE     4'hB
`define LCRB_IDX_ROM      2'h0
`define LCRB_IDX_MIC      2'h1
`define LCRB_IDX_DIV      2'h2
`define LCRB_IDX_MODE     2'h3
`define LCRB_ROM_OVR      5
`define LCRB_ROM_DIN      4
`define LCRB_ROM_DOUT     3
`define LCRB_ROM_CLK      2
`define LCRB_ROM_CS       1
`define LCRB_ROM_VLD      0
`define LCRB_MIC_P1_LSB   2
`define LCRB_MIC_P0_LSB   0
`define LCRB_DIV_UART_LSB 3
`define LCRB_DIV_IRQ_LSB  0
`define LCRB_ROM_CTL_RST  3'h0
`define LCRB_MIC_RST      4'h0
`define LCRB_DIV_UART_RST 3'h0
`define LCRB_DIV_IRQ_RST  3'h5
`define LCRB_RD_RST       8'h00
`endif

//--- lcrb_pkg.sv
// Types shared by the local configuration register bank.
// Assumes lcrb_defs.svh is on the include path.
package lcrb_pkg;
   // Multipurpose pin modes, two bits per pin
   typedef enum logic [1:0] {
      LCRB_PIN_IN      = 2'h0,
      LCRB_PIN_IN_INV  = 2'h1,
      LCRB_PIN_OUT_LO  = 2'h2,
      LCRB_PIN_OUT_HI  = 2'h3
   } lcrb_pin_mode_t;
   // Pulse interrupt sequencer, one-hot
   typedef enum logic [2:0] {
      LCRB_IP_IDLE  = 3'h1,
      LCRB_IP_WAIT  = 3'h2,
      LCRB_IP_PULSE = 3'h4
   } lcrb_ip_state_t;
endpackage

//--- lcrb_pow2_div.sv
// Power-of-two tick generator: one-cycle tick every 2**div_i clocks.
// Assumes div_i comes from registers on the same clock.
`timescale 1ns/1ns
module lcrb_pow2_div
   import lcrb_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input  wire logic             core_clk_i, // System clock
   input  wire logic             resetn_i,   // Sync reset, active low
   input  wire logic [DIV_W-1:0] div_i,      // Log2 of ratio
   output logic                  tick_o      // Tick, one cycle
);
   localparam int CW = (1 << DIV_W) - 1;

   generate
      if (DIV_W < 1 || DIV_W > 4) begin : g_chk
         $error("lcrb_pow2_div: DIV_W must be 1 to 4");
      end
   endgenerate

   function automatic logic [CW-1:0] low_mask(input logic [DIV_W-1:0] n);
      logic [CW-1:0] m;
      m = '0;
      for (int i = 0; i < CW; i++) begin
         m[i] = (i < int'(n));
      end
      return m;
   endfunction

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          tick_r;
   logic          tick_nxt;
   logic [CW-1:0] mask;

   always_comb begin
      mask     = low_mask(div_i);
      cnt_nxt  = CW'(cnt_r + 1'b1);
      // Ratio 1 gives all-zero mask, so the tick is always high
      tick_nxt = ((cnt_r & mask) == mask);
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;
endmodule // lcrb_pow2_div

//--- lcrb_rom_model.sv
// Serial config ROM stand-in: returns the last bit clocked in, inverted when deselected.
// Assumes its pins come from lcrb_bank on the same system clock.
`timescale 1ns/1ns
module lcrb_rom_model (
   input  wire logic core_clk_i, // System clock
   input  wire logic sel_i,      // Chip select, active high
   input  wire logic sck_i,      // Serial clock from the bank
   input  wire logic sdi_i,      // Data into the ROM
   output logic      sdo_o       // Data out of the ROM
);
   logic sck_q = 1'b0;
   logic bit_q = 1'b0;
   always @(posedge core_clk_i) begin
      sck_q <= sck_i;
      if (sel_i && sck_i && !sck_q) begin
         bit_q <= sdi_i;
      end
   end
   // Deselected line shows the inverse, so a stale copy never matches
   assign sdo_o = sel_i ? bit_q : ~bit_q;
endmodule // lcrb_rom_model

//--- testbench.sv
// Self-checking bench for lcrb_bank with a serial ROM model.
// Assumes one 250 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns
module testbench;
   import lcrb_pkg::*;
   logic       clk, rstn, ovl, hrd, hwr, lwr, lhdr, lovr, lbusy;
   logic       lcs, lck, ldo, absent, din, dout, sck, scs, mode;
   logic       utick, ireq, ipulse;
   logic [3:0] haddr, laddr;
   logic [7:0] hwd, lwd, hrdata;
   logic [1:0] mpi, mpo, mpoe, pst;
   int         err_count, compares, cyc;
   ////////////////////////////////////////////////////////////////////////
   lcrb_bank #(.DIV_W(3)) lcrb_bank_i (.core_clk_i(clk), .resetn_i(rstn),
      .overlay_i(ovl), .host_rd_i(hrd), .host_wr_i(hwr),
      .host_addr_i(haddr), .host_wdata_i(hwd), .host_rdata_o(hrdata),
      .ldr_wr_i(lwr), .ldr_addr_i(laddr), .ldr_wdata_i(lwd),
      .ldr_hdr_ok_i(lhdr), .ldr_overrun_i(lovr), .ldr_busy_i(lbusy),
      .ldr_cs_i(lcs), .ldr_ck_i(lck), .ldr_do_i(ldo),
      .rom_absent_o(absent), .serial_rom_data_in_pin_i(din),
      .serial_rom_data_out_pin_o(dout), .serial_rom_clock_pin_o(sck),
      .serial_rom_select_pin_o(scs), .mode_pin_i(mode),
      .multipurpose_pins_i(mpi), .multipurpose_pins_o(mpo),
      .multipurpose_pins_oe_o(mpoe), .pin_state_o(pst),
      .uart_clk_en_o(utick), .irq_pulse_req_i(ireq),
      .irq_pulse_o(ipulse));
   lcrb_rom_model lcrb_rom_model_i (.core_clk_i(clk), .sel_i(scs),
      .sck_i(sck), .sdi_i(dout), .sdo_o(din));
   ////////////////////////////////////////////////////////////////////////
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic test_done;
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      hwr   <= 1'b1;
      haddr <= a;
      hwd   <= d;
      @(posedge clk);
      hwr <= 1'b0;
      #1;
   endtask
   task automatic lw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      lwr   <= 1'b1;
      laddr <= a;
      lwd   <= d;
      @(posedge clk);
      lwr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      hrd   <= 1'b1;
      haddr <= a;
      @(posedge clk);
      hrd <= 1'b0;
      #1;
      chk(hrdata, exp);
   endtask
   // Cycles between two uart ticks, the first gap discarded
   task automatic gap(output int g);
      int i;
      for (i = 0; i < 2; i++) begin
         g = 0;
         do begin
            @(posedge clk);
            #1;
            g++;
         end while (utick !== 1'b1 && g < 300);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      int g;
      // Data input bit lags its pin by two synchroniser stages
      repeat (2) @(posedge clk);
      rdc(4'h8, 8'h10);
      rdc(4'h9, 8'h00);
      rdc(4'hA, 8'h05);
      rdc(4'hB, 8'h01);
      chk({7'h0, absent}, 8'h01);
      gap(g);
      chk(8'(g), 8'h01);
   endtask
   task automatic t_ctrl;
      logic [7:0] w[4] = '{8'hFF, 8'h02, 8'h06, 8'h00};
      logic [7:0] e[4] = '{8'h1E, 8'h12, 8'h06, 8'h10};
      for (int i = 0; i < 4; i++) begin
         wr(4'h8, w[i]);
         chk({5'h0, dout, sck, scs}, {5'h0, w[i][3:1]});
         repeat (4) @(posedge clk);
         rdc(4'h8, e[i]);
      end
   endtask
   task automatic t_mic;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         mpi <= c ^ 2'h2;
         wr(4'h9, {4'hF, c, c});
         chk({6'h0, mpoe}, {6'h0, c[1], c[1]});
         chk({6'h0, mpo}, {6'h0, c[0], c[0]});
         repeat (5) @(posedge clk);
         #1;
         chk({6'h0, pst}, {6'h0, c[1] ? {c[0], c[0]} :
             (c ^ 2'h2) ^ {c[0], c[0]}});
         rdc(4'h9, {4'h0, c, c});
      end
   endtask
   task automatic t_uart;
      int g;
      for (int n = 0; n < 8; n++) begin
         wr(4'hA, {2'h3, 3'(n), 3'h5});
         rdc(4'hA, {2'h0, 3'(n), 3'h5});
         gap(g);
         chk(8'(g), 8'(1 << n));
      end
   endtask
   task automatic t_irq;
      logic [2:0] code[4] = '{3'h0, 3'h1, 3'h2, 3'h5};
      int k;
      for (int i = 0; i < 4; i++) begin
         wr(4'hA, {5'h0, code[i]});
         ireq <= 1'b1;
         @(posedge clk);
         ireq <= 1'b0;
         for (k = 0; k < 300 && ipulse !== 1'b1; k++) @(posedge clk) #1;
         for (k = 0; k < 300 && ipulse === 1'b1; k++) @(posedge clk) #1;
         chk(8'(k), 8'(1 << code[i]));
      end
   endtask
   task automatic t_ldr;
      ovl  <= 1'b1;
      mode <= 1'b0;
      lw(4'hA, 8'h2A);
      rdc(4'h2, 8'h2A);
      lw(4'h9, 8'h0D);
      lw(4'h8, 8'hFF);
      rdc(4'h1, 8'h0D);
      rdc(4'h0, 8'h10);
      rdc(4'h3, 8'h00);
      ovl <= 1'b0;
      rdc(4'h2, 8'h00);
      rdc(4'hC, 8'h00);
      lhdr <= 1'b1;
      @(posedge clk);
      lhdr <= 1'b0;
      rdc(4'h8, 8'h11);
      chk({7'h0, absent}, 8'h00);
      lovr <= 1'b1;
      @(posedge clk);
      lovr <= 1'b0;
      rdc(4'h8, 8'h30);
      chk({7'h0, absent}, 8'h01);
      lbusy <= 1'b1;
      lcs   <= 1'b1;
      ldo   <= 1'b1;
      @(posedge clk);
      #1;
      chk({5'h0, dout, sck, scs}, 8'h05);
      lbusy <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, rstn, ovl, hrd, hwr, lwr, lhdr, lovr, lbusy} = '0;
      {lcs, lck, ldo, ireq, haddr, laddr, hwd, lwd, mpi} = '0;
      mode = 1'b1;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_ctrl();
      t_mic();
      t_uart();
      t_irq();
      t_ldr();
      test_done();
   end
endmodule // testbench
